/* scfc_regs.svh */
// Register offsets, field positions, the control reset value and the fail limit for the frame codec
`ifndef SCFC_REGS_SVH
`define SCFC_REGS_SVH
// ----------------------------------------
// Frame geometry and the fail limit
// ----------------------------------------
`define SCFC_FRAME_BITS 48
`define SCFC_PRE_BITS 16
`define SCFC_DATA_BITS 32
`define SCFC_SYNC_PATTERN 6'h3e
`define SCFC_BIT_TX 6
`define SCFC_BIT_RX 7
`define SCFC_BIT_LOCK 8
`define SCFC_BIT_MONREQ 9
`define SCFC_BIT_ADDR_LO 10
`define SCFC_BIT_ID_LO 12
`define SCFC_FAIL_LIMIT 3
// ----------------------------------------
// Word numbers and field positions (frame bit numbers)
// ----------------------------------------
`define SCFC_WORD_MON 4'h0
`define SCFC_WORD_FREQ 4'h1
`define SCFC_WORD_ANA 4'h2
`define SCFC_WORD_MODE 4'h5
`define SCFC_F_FREQ_LO 16
`define SCFC_F_SINGLE 46
`define SCFC_F_BOFS_LO 16
`define SCFC_F_BOFS_SIGN 27
`define SCFC_F_IFG_LO 39
`define SCFC_F_MODE_LO 28
`define SCFC_F_MODE_GRP 32
`define SCFC_F_DECAY 36
`define SCFC_F_AGC_LO 37
`define SCFC_F_FILT_LO 40
`define SCFC_F_USER_LO 44
`define SCFC_F_MUTE 32
`define SCFC_F_FAULT 33
`define SCFC_F_CMPF 34
`define SCFC_F_METER_SEL 36
`define SCFC_F_METER_LO 40
// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define SCFC_REG_CTRL 8'h00
`define SCFC_REG_STATUS 8'h04
`define SCFC_REG_FREQ 8'h08
`define SCFC_REG_ANALOG 8'h0c
`define SCFC_REG_MODE 8'h10
`define SCFC_REG_METER 8'h14
`define SCFC_CTRL_RESET 32'h0000_0000
`endif

/* scfc_pkg.sv */
// Types shared by the frame codec
package scfc_pkg;
	typedef enum logic [1:0] {
		SCFC_MD_SIDEBAND,
		SCFC_MD_SYMM,
		SCFC_MD_INVALID
	} scfc_mode_grp_t;
	typedef enum logic {
		SCFC_HUNT,
		SCFC_FRAME
	} scfc_rx_state_t;
	typedef logic [47:0] scfc_frame_t;
endpackage

/* scfc_codec.sv */
// Serial control frame receiver, comparator, decoder and revertive framer
// How it works
// - Frames are 16-bit preamble plus 32-bit data.
// - Preamble bits 12-15 hold word number.
// - Zero then five ones marks frame start.
// - Bit 6 transmit, bit 7 receive state.
// - Lock bit freezes settings; revertive continues.
// - Address bits 10-11 must be zero.
// - Two identical consecutive frames apply settings.
// - Link option accepts single frequency frames.
// - Forced zeros keep data free of sync.
// - Forward word 0 changes only the bit 6-7 state.
// - Revertive word 0 bits 16-19 user inputs.
// - Revertive bits 32 mute, 33 fault.
// - Bit 34 set after three failed comparisons.
// - Bit 36 meter select, reading bits 40-47.
// - Word 1 BCD frequency, bits 46-47 check.
// - Word 2 bit 27 negative offset sign.
// - IF gain bits 39-42, 44-47, 43 zero.
// - Word 5 mode code and group bit.
// - Word 5 bit 36 fast gain decay.
// - Word 5 bits 37-39 gain loop mode.
// - Word 5 bits 40-42 filter select.
// - Word 5 last four bits user outputs.
//
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "scfc_regs.svh"
module scfc_codec
	import scfc_pkg::*;
#(
	parameter int FRAME_BITS = `SCFC_FRAME_BITS
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Classic Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Forward link from the controller
	input wire logic fwd_clk_i,
	input wire logic fwd_data_i,
	// Revertive link towards the controller
	input wire logic rev_clk_i,
	output logic rev_data_o,
	// Receiver side signals
	input wire logic [3:0] user_in_i,
	input wire logic mute_in_i,
	input wire logic synth_fault_i,
	input wire logic [6:0] meter_i,
	input wire logic single_freq_link_i,
	output logic [1:0] transmit_receive_code_o,
	output logic receiver_mute_o,
	output logic [29:0] freq_bcd_o,
	output logic [11:0] beat_oscillator_offset_o,
	output logic [7:0] if_gain_o,
	output logic [3:0] mode_code_o,
	output logic mode_group_o,
	output logic gain_loop_fast_decay_o,
	output logic [2:0] agc_mode_o,
	output logic [2:0] filter_sel_o,
	output logic [3:0] user_out_o,
	output logic comparison_fail_flag_o
);
	// ----------------------------------------
	// Reset release and synchronisers
	// ----------------------------------------
	logic [1:0] rst_sync;
	logic rst_n;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];
	default clocking cb_core @(posedge core_clk_i); endclocking
	default disable iff (!rst_n);
	logic [1:0] s_fclk, s_fdat, s_rclk;
	logic fclk_d, rclk_d;
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s_fclk <= 2'h0;
			s_fdat <= 2'h0;
			s_rclk <= 2'h0;
			fclk_d <= 1'b0;
			rclk_d <= 1'b0;
		end else begin
			s_fclk <= {s_fclk[0], fwd_clk_i};
			s_fdat <= {s_fdat[0], fwd_data_i};
			s_rclk <= {s_rclk[0], rev_clk_i};
			fclk_d <= s_fclk[1];
			rclk_d <= s_rclk[1];
		end
	end
	logic fbit_en, rbit_en;
	assign fbit_en = s_fclk[1] && !fclk_d;
	assign rbit_en = !s_rclk[1] && rclk_d;

	// ----------------------------------------
	// Forward receiver and sync hunt
	// ----------------------------------------
	scfc_rx_state_t rx_state;
	scfc_frame_t shreg, rx_frame;
	logic [5:0] sync_win, bit_cnt;
	logic frame_done, sync_hit;
	// zero followed by five ones, first bit oldest
	assign sync_hit = ({s_fdat[1], sync_win[5:1]} == `SCFC_SYNC_PATTERN);
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rx_state <= SCFC_HUNT;
			sync_win <= 6'h00;
			shreg <= 48'h0000_0000_0000;
			bit_cnt <= 6'h00;
			frame_done <= 1'b0;
			rx_frame <= 48'h0000_0000_0000;
		end else begin
			frame_done <= 1'b0;
			if (fbit_en) begin
				sync_win <= {s_fdat[1], sync_win[5:1]};
				shreg <= {s_fdat[1], shreg[47:1]};
				// realign the counter on every sync
				if (sync_hit) begin
					rx_state <= SCFC_FRAME;
					bit_cnt <= 6'd6;
				end else if (rx_state == SCFC_FRAME) begin
					if (bit_cnt == 6'(FRAME_BITS - 1)) begin
						rx_state <= SCFC_HUNT;
						frame_done <= 1'b1;
						rx_frame <= {s_fdat[1], shreg[47:1]};
						bit_cnt <= 6'h00;
					end else begin
						bit_cnt <= bit_cnt + 6'd1;
					end
				end
			end
		end
	end

	// ----------------------------------------
	// Frame comparison
	// ----------------------------------------
	function automatic logic [3:0] word_id(input scfc_frame_t f);
		// word number in preamble bits 12-15
		word_id = f[`SCFC_BIT_ID_LO +: 4];
	endfunction
	scfc_frame_t prev_frame;
	logic [1:0] fail_cnt;
	logic [3:0] rev_word;
	logic prev_valid, cmp_fail, apply_now, pair_ok, single_ok, addr_ok;
	assign pair_ok = prev_valid && (prev_frame == rx_frame);
	assign addr_ok = (rx_frame[`SCFC_BIT_ADDR_LO +: 2] == 2'h0);
	assign single_ok = single_freq_link_i && (word_id(rx_frame) == `SCFC_WORD_FREQ);
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			prev_frame <= 48'h0000_0000_0000;
			prev_valid <= 1'b0;
			fail_cnt <= 2'h0;
			cmp_fail <= 1'b0;
			apply_now <= 1'b0;
			rev_word <= 4'h0;
		end else begin
			apply_now <= 1'b0;
			if (frame_done) begin
				// a matched pair is consumed whole
				if (pair_ok) begin
					prev_valid <= 1'b0;
					fail_cnt <= 2'h0;
					cmp_fail <= 1'b0;
					apply_now <= addr_ok;
					rev_word <= word_id(rx_frame);
				end else if (single_ok) begin
					prev_valid <= 1'b0;
					apply_now <= addr_ok;
					rev_word <= `SCFC_WORD_FREQ;
				end else begin
					prev_frame <= rx_frame;
					prev_valid <= 1'b1;
					rev_word <= `SCFC_WORD_MON;
					// flag after three failures in a row
					if (prev_valid) begin
						if (fail_cnt == 2'(`SCFC_FAIL_LIMIT - 1)) begin
							cmp_fail <= 1'b1;
						end else begin
							fail_cnt <= fail_cnt + 2'd1;
						end
					end
				end
				// monitor request forces word 0 back
				if (rx_frame[`SCFC_BIT_MONREQ]) begin
					rev_word <= `SCFC_WORD_MON;
				end
			end
		end
	end
	// ----------------------------------------
	// Settings decode
	// ----------------------------------------
	logic lock;
	assign lock = rx_frame[`SCFC_BIT_LOCK];
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			transmit_receive_code_o <= 2'h2;
			receiver_mute_o <= 1'b0;
			freq_bcd_o <= 30'h0000_0000;
			beat_oscillator_offset_o <= 12'h000;
			if_gain_o <= 8'h00;
			mode_code_o <= 4'h0;
			mode_group_o <= 1'b0;
			gain_loop_fast_decay_o <= 1'b0;
			agc_mode_o <= 3'h0;
			filter_sel_o <= 3'h2;
			user_out_o <= 4'h0;
		end else begin
			gain_loop_fast_decay_o <= 1'b0;
			// lock bit leaves all settings alone
			if (apply_now && !lock) begin
				// 01 transmit mutes, 10 receive; 11 is refused
				if (rx_frame[`SCFC_BIT_RX:`SCFC_BIT_TX] != 2'h3) begin
					transmit_receive_code_o <= rx_frame[`SCFC_BIT_RX:`SCFC_BIT_TX];
					receiver_mute_o <= (rx_frame[`SCFC_BIT_RX:`SCFC_BIT_TX] == 2'h1);
				end
				// word 0 matches no case below
				unique case (word_id(rx_frame))
					`SCFC_WORD_FREQ: begin
						freq_bcd_o <= rx_frame[`SCFC_F_FREQ_LO +: 30];
					end
					`SCFC_WORD_ANA: begin
						beat_oscillator_offset_o <= rx_frame[`SCFC_F_BOFS_LO +: 12];
						// gain skips forced zero bit 43
						if_gain_o <= {rx_frame[47:44], rx_frame[42:39]};
					end
					`SCFC_WORD_MODE: begin
						mode_code_o <= rx_frame[`SCFC_F_MODE_LO +: 4];
						mode_group_o <= rx_frame[`SCFC_F_MODE_GRP];
						gain_loop_fast_decay_o <= rx_frame[`SCFC_F_DECAY];
						if (rx_frame[`SCFC_F_AGC_LO +: 3] != 3'h7) begin
							agc_mode_o <= rx_frame[`SCFC_F_AGC_LO +: 3];
						end
						// only codes 2-6 select a filter
						if (rx_frame[`SCFC_F_FILT_LO +: 3] >= 3'h2 &&
							rx_frame[`SCFC_F_FILT_LO +: 3] <= 3'h6) begin
							filter_sel_o <= rx_frame[`SCFC_F_FILT_LO +: 3];
						end
						user_out_o <= rx_frame[`SCFC_F_USER_LO +: 4];
					end
					default: ;
				endcase
			end
		end
	end
	// ----------------------------------------
	// Revertive framer
	// ----------------------------------------
	logic meter_sel;
	function automatic scfc_frame_t build_rev(input logic [3:0] w);
		scfc_frame_t f;
		f = 48'h0000_0000_0000;
		f[5:0] = `SCFC_SYNC_PATTERN;
		// at most one of bits 6-7 is sent set
		f[`SCFC_BIT_TX +: 2] = transmit_receive_code_o;
		f[`SCFC_BIT_ID_LO +: 4] = w;
		unique case (w)
			`SCFC_WORD_FREQ: begin
				f[`SCFC_F_FREQ_LO +: 30] = freq_bcd_o;
			end
			`SCFC_WORD_ANA: begin
				f[`SCFC_F_BOFS_LO +: 12] = beat_oscillator_offset_o & 12'hf7f;
				f[47:44] = if_gain_o[7:4];
				f[42:39] = if_gain_o[3:0];
			end
			`SCFC_WORD_MODE: begin
				f[`SCFC_F_MODE_LO +: 4] = mode_code_o;
				f[`SCFC_F_MODE_GRP] = mode_group_o;
				f[`SCFC_F_AGC_LO +: 3] = agc_mode_o;
				f[`SCFC_F_FILT_LO +: 3] = filter_sel_o;
				f[`SCFC_F_USER_LO +: 4] = user_out_o;
			end
			default: begin
				f[16 +: 4] = user_in_i;
				f[`SCFC_F_MUTE] = mute_in_i;
				f[`SCFC_F_FAULT] = synth_fault_i;
				f[`SCFC_F_CMPF] = cmp_fail;
				f[`SCFC_F_METER_SEL] = meter_sel;
				if (meter_sel) begin
					f[42:40] = meter_i[2:0];
					f[47:44] = meter_i[6:3];
				end
			end
		endcase
		// forced zero bit 43 in every word
		f[43] = 1'b0;
		build_rev = f;
	endfunction
	scfc_frame_t tx_sh, rev_next;
	logic [5:0] tx_cnt;
	always_comb begin
		rev_next = build_rev(rev_word);
	end
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tx_sh <= 48'h0000_0000_0000;
			tx_cnt <= 6'h00;
			rev_data_o <= 1'b0;
		end else begin
			if (rbit_en) begin
				// next bit out on each clock fall
				if (tx_cnt == 6'h00) begin
					tx_sh <= rev_next >> 1;
					rev_data_o <= rev_next[0];
					tx_cnt <= 6'(FRAME_BITS - 1);
				end else begin
					rev_data_o <= tx_sh[0];
					tx_sh <= tx_sh >> 1;
					tx_cnt <= tx_cnt - 6'd1;
				end
			end
		end
	end

	// ----------------------------------------
	// Wishbone registers
	// ----------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			meter_sel <= 1'b0;
			comparison_fail_flag_o <= 1'b0;
		end else begin
			comparison_fail_flag_o <= cmp_fail;
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
				if (wb_we_i && wb_adr_i == `SCFC_REG_CTRL && wb_sel_i[0]) begin
					meter_sel <= wb_dat_i[0];
				end
				unique case (wb_adr_i)
					`SCFC_REG_CTRL: wb_dat_o <= {31'h0000_0000, meter_sel};
					`SCFC_REG_STATUS: wb_dat_o <= {24'h00_0000, rev_word, 1'b0,
						rx_state == SCFC_FRAME, prev_valid, cmp_fail};
					`SCFC_REG_FREQ: wb_dat_o <= {2'h0, freq_bcd_o};
					`SCFC_REG_ANALOG: wb_dat_o <= {12'h000, if_gain_o, beat_oscillator_offset_o};
					`SCFC_REG_MODE: wb_dat_o <= {14'h0000, transmit_receive_code_o, user_out_o,
						filter_sel_o, agc_mode_o, mode_group_o, mode_code_o, 1'b0};
					`SCFC_REG_METER: wb_dat_o <= {25'h000_0000, meter_i};
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_fail_flag; (frame_done && pair_ok) |=> !cmp_fail; endproperty
	a_fail_flag: assert property (p_fail_flag) else $error("fail flag not cleared");
	property p_lock; (apply_now && lock) |=> $stable(freq_bcd_o) && $stable(mode_code_o); endproperty
	a_lock: assert property (p_lock) else $error("settings changed while locked");
	property p_pair; (frame_done && !pair_ok && !single_ok) |=> !apply_now; endproperty
	a_pair: assert property (p_pair) else $error("applied without pair");
	property p_trx; transmit_receive_code_o != 2'h3; endproperty
	a_trx: assert property (p_trx) else $error("both state bits set");
	property p_frame_len; frame_done |-> $past(bit_cnt) == 6'd47; endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
	property p_wb_ack; wb_ack_o |=> !wb_ack_o; endproperty
	a_wb_ack: assert property (p_wb_ack) else $error("ack held two cycles");
	property p_agc; agc_mode_o != 3'h7; endproperty
	a_agc: assert property (p_agc) else $error("illegal gain loop code");
	property p_filt; filter_sel_o >= 3'h2 && filter_sel_o <= 3'h6; endproperty
	a_filt: assert property (p_filt) else $error("illegal filter code");
	c_apply: cover property (apply_now);
	c_fail: cover property ($rose(cmp_fail));
	c_decay: cover property (gain_loop_fast_decay_o);
endmodule

/* scfc_ctrl_model.sv */
// Controller-side model: drives the forward link and clocks in the revertive link
`timescale 1ns/100ps
module scfc_ctrl_model
	import scfc_pkg::*;
#(
	parameter int HALF_NS = 80
) (
	// Forward link
	output logic fwd_clk_o,
	output logic fwd_data_o,
	// Revertive link
	output logic rev_clk_o,
	input wire logic rev_data_i
);
	scfc_frame_t rev_frame;
	initial begin
		fwd_clk_o = 1'b0;
		fwd_data_o = 1'b0;
		rev_clk_o = 1'b0;
		rev_frame = '0;
	end
	task automatic send_frame(input scfc_frame_t frame);
		// Keeps link edges off the core clock edges
		#1.3;
		for (int k = 0; k < 48; k++) begin
			fwd_data_o = frame[k];
			#(HALF_NS);
			fwd_clk_o = 1'b1;
			rev_clk_o = 1'b1;
			if (k > 0) begin
				rev_frame[k - 1] = rev_data_i;
			end
			#(HALF_NS);
			fwd_clk_o = 1'b0;
			rev_clk_o = 1'b0;
		end
		// Released line shows the inverse of the last bit
		fwd_data_o = ~frame[47];
		#(HALF_NS);
		rev_frame[47] = rev_data_i;
	endtask
endmodule

/* scfc_codec_bench.sv */
// Self-checking bench for the serial control frame codec
`timescale 1ns/100ps
module scfc_codec_bench
	import scfc_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [31:0] wb_dat = 32'h0000_0000;
	logic [31:0] wb_rd;
	logic [31:0] rd;
	logic wb_ack, fwd_clk, fwd_data, rev_clk, rev_data;
	logic [3:0] user_in = 4'h0;
	logic mute_in = 1'b0;
	logic fault_in = 1'b0;
	logic [6:0] meter = 7'h00;
	logic link_en = 1'b0;
	logic [1:0] trx;
	logic mute, mgrp, decay, cflag;
	logic [29:0] freq;
	logic [11:0] bofs;
	logic [7:0] gain;
	logic [3:0] mcode, user_out;
	logic [2:0] agc, filt;
	int n_fail = 0;
	int n_tests = 0;
	int n_decay = 0;
	always #2 clk = ~clk;
	always @(posedge clk) begin
		if (decay === 1'b1) begin
			n_decay <= n_decay + 1;
		end
	end
	scfc_codec dut_u (
		.core_clk_i(clk), .rst_n_i(rst_n),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
		.fwd_clk_i(fwd_clk), .fwd_data_i(fwd_data), .rev_clk_i(rev_clk), .rev_data_o(rev_data),
		.user_in_i(user_in), .mute_in_i(mute_in), .synth_fault_i(fault_in), .meter_i(meter),
		.single_freq_link_i(link_en), .transmit_receive_code_o(trx), .receiver_mute_o(mute),
		.freq_bcd_o(freq), .beat_oscillator_offset_o(bofs), .if_gain_o(gain),
		.mode_code_o(mcode), .mode_group_o(mgrp), .gain_loop_fast_decay_o(decay),
		.agc_mode_o(agc), .filter_sel_o(filt), .user_out_o(user_out),
		.comparison_fail_flag_o(cflag)
	);
	scfc_ctrl_model ctl_u (
		.fwd_clk_o(fwd_clk), .fwd_data_o(fwd_data), .rev_clk_o(rev_clk), .rev_data_i(rev_data)
	);
	task automatic end_of_test();
		if (n_fail == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
			output logic [31:0] rdat);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dat <= wdat;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		rdat = wb_rd;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (wb_ack !== 1'b1) begin
			n_fail++;
			end_of_test();
		end else begin
			@(posedge clk);
		end
	endtask
	function automatic scfc_frame_t mk(input logic [3:0] word, input logic [1:0] tr,
			input logic [3:0] ctl, input logic [31:0] data);
		return {data, word, ctl, tr, 6'h3e};
	endfunction
	function automatic logic [31:0] w5(input logic [3:0] c, input logic g, input logic dc,
			input logic [2:0] a, input logic [2:0] fl, input logic [3:0] u);
		return {u, 1'b0, fl, a, dc, 3'b000, g, c, 12'h000};
	endfunction
	function automatic logic [31:0] w2(input logic [11:0] ofs, input logic [7:0] g);
		return {g[7:4], 1'b0, g[3:0], 11'h000, ofs};
	endfunction
	// sends the frame once, then waits 12 core clocks
	task automatic send(input scfc_frame_t f);
		ctl_u.send_frame(f);
		repeat (12) @(posedge clk);
	endtask
	task automatic chk_w5(input logic [3:0] c, input logic g, input logic [2:0] a,
			input logic [2:0] fl, input logic [3:0] u);
		check("mode code", mcode, c);
		check("mode group", mgrp, g);
		check("gain loop mode", agc, a);
		check("filter", filt, fl);
		check("user out", user_out, u);
	endtask
	task automatic t_reset();
		check("reset state code", trx, 2'b10);
		check("reset filter", filt, 3'h2);
		check("reset flag", cflag, 1'b0);
		wb_xfer(1'b0, 8'h00, 32'h0000_0000, rd);
		check("ctrl reset", rd, 32'h0000_0000);
		wb_xfer(1'b1, 8'h10, 32'hffff_ffff, rd);
		wb_xfer(1'b0, 8'h10, 32'h0000_0000, rd);
		check("mode register", rd, 32'h0002_0400);
		wb_xfer(1'b1, 8'h40, 32'hffff_ffff, rd);
		wb_xfer(1'b0, 8'h40, 32'h0000_0000, rd);
		check("unmapped", rd, 32'h0000_0000);
	endtask
	task automatic t_modes();
		logic [3:0] code [7] = '{4'h1, 4'h2, 4'h5, 4'h0, 4'h1, 4'h2, 4'h3};
		logic [6:0] grp = 7'h07;
		logic [1:0] tr;
		logic [2:0] fl;
		scfc_frame_t f;
		for (int i = 0; i < 7; i++) begin
			tr = i[0] ? 2'b10 : 2'b01;
			fl = 3'(2 + i % 5);
			f = mk(4'h5, tr, 4'h0, w5(code[i], grp[i], i == 0, i[2:0], fl, i[3:0]));
			send(f);
			send(f);
			chk_w5(code[i], grp[i], i[2:0], fl, i[3:0]);
			check("state code", trx, tr);
			check("mute", mute, tr == 2'b01);
		end
		check("decay pulses", n_decay, 1);
	endtask
	task automatic t_refuse();
		logic [3:0] ctl [3] = '{4'h1, 4'h4, 4'h0};
		logic [3:0] word [3] = '{4'h5, 4'h5, 4'h0};
		scfc_frame_t f;
		for (int i = 0; i < 3; i++) begin
			f = mk(word[i], 2'b10, ctl[i], w5(4'h1, 1'b1, 1'b0, 3'h4, 3'h5, 4'h9));
			send(f);
			send(f);
			chk_w5(4'h3, 1'b0, 3'h6, 3'h3, 4'h6);
			check("revertive sync", ctl_u.rev_frame[5:0], 6'h3e);
		end
		f = mk(4'h5, 2'b10, 4'h0, w5(4'h3, 1'b0, 1'b1, 3'h7, 3'h0, 4'h6));
		send(f);
		send(f);
		chk_w5(4'h3, 1'b0, 3'h6, 3'h3, 4'h6);
		check("decay on refused codes", n_decay, 2);
	endtask
	task automatic t_fail();
		scfc_frame_t e;
		wb_xfer(1'b1, 8'h00, 32'h0000_0001, rd);
		user_in <= 4'ha;
		mute_in <= 1'b1;
		fault_in <= 1'b1;
		meter <= 7'h55;
		send(mk(4'h5, 2'b10, 4'h0, w5(4'h1, 1'b1, 1'b0, 3'h4, 3'h5, 4'h9)));
		send(mk(4'h5, 2'b10, 4'h0, w5(4'h2, 1'b1, 1'b0, 3'h4, 3'h5, 4'h9)));
		chk_w5(4'h3, 1'b0, 3'h6, 3'h3, 4'h6);
		send(mk(4'h2, 2'b10, 4'h0, w2(12'h123, 8'h11)));
		check("flag after two", cflag, 1'b0);
		send(mk(4'h1, 2'b10, 4'h0, {2'b00, 30'h0234_5678}));
		check("flag after three", cflag, 1'b1);
		check("unpaired freq", freq, 30'h0000_0000);
		wb_xfer(1'b0, 8'h04, 32'h0000_0000, rd);
		check("status flag", rd[0], 1'b1);
		e = mk(4'h2, 2'b10, 4'h0, w2(12'hb75, 8'ha5));
		send(e);
		check("rev word", ctl_u.rev_frame[15:12], 4'h0);
		check("rev user", ctl_u.rev_frame[19:16], 4'ha);
		check("rev mute fault", ctl_u.rev_frame[33:32], 2'b11);
		check("rev fail bit", ctl_u.rev_frame[34], 1'b1);
		check("rev meter", {ctl_u.rev_frame[36], ctl_u.rev_frame[47:40]}, 9'h1a5);
		send(e);
		check("offset", bofs, 12'hb75);
		check("gain", gain, 8'ha5);
		check("flag cleared", cflag, 1'b0);
	endtask
	task automatic t_single();
		link_en <= 1'b1;
		@(posedge clk);
		send(mk(4'h1, 2'b10, 4'h0, {2'b00, 30'h0123_4567}));
		check("single freq", freq, 30'h0123_4567);
		check("rev analogue word", ctl_u.rev_frame[15:12], 4'h2);
		check("rev offset", ctl_u.rev_frame[27:16], 12'hb75);
		check("rev gain", {ctl_u.rev_frame[47:44], ctl_u.rev_frame[42:39]}, 8'ha5);
		check("rev forced zero", ctl_u.rev_frame[43], 1'b0);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		t_reset();
		t_modes();
		t_refuse();
		t_fail();
		t_single();
		end_of_test();
	end
endmodule
